// ### rpc_far_model.sv
// far-side model: selected clock source and reset pin driver
`timescale 1ns/10ps
module rpc_far_model (
   input  wire logic hclk,
   input  wire logic clk_source_start,
   input  wire logic slow,
   input  wire logic pin_low,
   output logic      clk_source_tick,
   output logic      reset_pin_n
);
   logic phase_q;

   // source stands still until started; slow mode ticks every other cycle
   always_ff @(posedge hclk) begin
      phase_q         <= clk_source_start ? ~phase_q : 1'b0;
      clk_source_tick <= clk_source_start && (!slow || phase_q);
   end

   // push-pull button source, so the pin always shows a real level
   assign reset_pin_n = !pin_low;
endmodule // rpc_far_model

// ### rpc_pkg.sv
// constants, register map and types of the reset and power-on controller
package rpc_pkg;

   // register word indices; byte address is four times the index
   localparam logic [7:0] ADDR_WDG_CLEAR   = 8'h86;
   localparam logic [7:0] ADDR_CAUSE       = 8'h80;
   localparam logic [7:0] ADDR_SOFT_RESET  = 8'h84;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h88;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h8c;

   // field positions and values
   localparam int         BIT_CAUSE_UV     = 7;
   localparam int         BIT_CAUSE_WDG    = 6;
   localparam int         BIT_CAUSE_PIN    = 5;
   localparam int         BIT_SOFT_REQ     = 0;
   localparam logic [7:0] WDG_CLEAR_VALUE  = 8'h5a;
   localparam logic [7:0] RESET_VECTOR_LO  = 8'h00;
   localparam logic [15:0] RESET_VECTOR    = 16'h0000;
   localparam logic [3:0] IRQ_RESET_VAL    = 4'h0;
   localparam int         IRQ_BITS         = 4;
   localparam int         IRQ_UV           = 0;
   localparam int         IRQ_WDG          = 1;
   localparam int         IRQ_PIN          = 2;
   localparam int         IRQ_SOFT         = 3;

   // timing
   localparam int CLK_HZ          = 50_000_000;
   localparam int PWR_STAB_MS     = 5;
   localparam int PWR_STAB_CYC    = CLK_HZ / 1000 * PWR_STAB_MS;
   localparam int CLK_STAB_PERIODS = 4096;
   localparam int DEBOUNCE_MS     = 8;
   localparam int DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int SLOW_OSC_HZ     = 16_000;
   localparam int SLOW_TICK_CYC   = CLK_HZ / SLOW_OSC_HZ;
   localparam int WDG_TICKS       = 256;

   typedef enum logic [1:0] {
      RPC_WDG_DISABLED,
      RPC_WDG_ENABLED,
      RPC_WDG_ALWAYS
   } rpc_wdg_mode_e;

   typedef enum logic [1:0] {
      RPC_CPU_NORMAL,
      RPC_CPU_IDLE,
      RPC_CPU_STOP
   } rpc_cpu_state_e;

   typedef enum {
      RPC_ST_HELD,
      RPC_ST_PWR_WAIT,
      RPC_ST_CLK_WAIT,
      RPC_ST_RUN
   } rpc_seq_e;

endpackage : rpc_pkg

// ### rpc_reset_ctrl.sv
// reset and power-on controller with ahb-lite register slave
`timescale 1ns/10ps
module rpc_reset_ctrl
   import rpc_pkg::*;
#(
   parameter int PWR_STAB_CYCLES = PWR_STAB_CYC,
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int SLOW_TICK_CYCLES = SLOW_TICK_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        undervoltage_level_low,
   input  wire logic        reset_pin_n,
   input  wire logic [1:0]  cfg_wdg_mode,
   input  wire logic [1:0]  cfg_wdg_prescale,
   input  wire logic        cfg_pin_reset_en,
   input  wire logic        cfg_pin_debounce,
   input  wire logic [2:0]  cfg_clk_source,
   input  wire logic [1:0]  cpu_state,
   input  wire logic        clk_source_tick,
   output logic             sys_reset_n,
   output logic             cpu_run,
   output logic [2:0]       clk_source_sel,
   output logic             clk_source_start,
   output logic [15:0]      fetch_address,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // reset pin synchroniser

   logic pin_meta_q;
   logic pin_sync_q;

   // two stages, only the second is read by logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta_q <= 1'b1;
         pin_sync_q <= 1'b1;
      end else begin
         pin_meta_q <= reset_pin_n;
         pin_sync_q <= pin_meta_q;
      end
   end

   logic uv_meta_q;
   logic uv_sync_q;

   // undervoltage report comes from an analog comparator
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         uv_meta_q <= 1'b0;
         uv_sync_q <= 1'b0;
      end else begin
         uv_meta_q <= undervoltage_level_low;
         uv_sync_q <= uv_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration capture

   rpc_seq_e      seq_q;
   logic [1:0]    wdg_mode_q;
   logic [1:0]    wdg_pre_q;
   logic          pin_en_q;
   logic          pin_deb_q;
   logic [2:0]    clk_sel_q;

   // straps are followed while held in reset and frozen once running
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdg_mode_q <= 2'h0;
         wdg_pre_q  <= 2'h0;
         pin_en_q   <= 1'b0;
         pin_deb_q  <= 1'b0;
      end else if (seq_q == RPC_ST_HELD) begin
         wdg_mode_q <= cfg_wdg_mode;
         wdg_pre_q  <= cfg_wdg_prescale;
         pin_en_q   <= cfg_pin_reset_en;
         pin_deb_q  <= cfg_pin_debounce;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external pin with optional debounce

   logic [31:0] deb_cnt_q;
   logic        pin_low;
   logic        pin_reset;

   assign pin_low = pin_en_q && !pin_sync_q;

   // counts continuous low time; any high restarts it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         deb_cnt_q <= 32'h0;
      end else if (!pin_low) begin
         deb_cnt_q <= 32'h0;
      end else if (deb_cnt_q < 32'(DEBOUNCE_CYCLES)) begin
         deb_cnt_q <= deb_cnt_q + 32'h1;
      end
   end

   assign pin_reset = pin_low &&
      (!pin_deb_q || deb_cnt_q >= 32'(DEBOUNCE_CYCLES));

   ////////////////////////////////////////////////////////////////////////
   // watchdog

   logic [31:0] slow_cnt_q;
   logic        slow_tick;
   logic [5:0]  pre_cnt_q;
   logic [7:0]  wdg_cnt_q;
   logic        wdg_count_en;
   logic        wdg_clear;
   logic        wdg_reset;
   logic [5:0]  pre_limit;

   // low-speed oscillator stand-in: enable pulse from hclk divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_cnt_q <= 32'h0;
      end else if (slow_cnt_q >= 32'(SLOW_TICK_CYCLES - 1)) begin
         slow_cnt_q <= 32'h0;
      end else begin
         slow_cnt_q <= slow_cnt_q + 32'h1;
      end
   end

   assign slow_tick = (slow_cnt_q >= 32'(SLOW_TICK_CYCLES - 1));
   assign pre_limit = 6'(6'd4 << wdg_pre_q);  // 4, 8, 16, 32

   // mode gating against cpu state
   always_comb begin
      unique case (wdg_mode_q)
         2'(RPC_WDG_ALWAYS):  wdg_count_en = 1'b1;
         2'(RPC_WDG_ENABLED): wdg_count_en =
            (cpu_state == 2'(RPC_CPU_NORMAL));
         default:             wdg_count_en = 1'b0;
      endcase
   end

   // prescaler then 256-tick timer; timer only runs once cpu runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt_q <= 6'h0;
         wdg_cnt_q <= 8'h0;
      end else if (wdg_clear || seq_q != RPC_ST_RUN) begin
         pre_cnt_q <= 6'h0;
         wdg_cnt_q <= 8'h0;
      end else if (wdg_count_en && slow_tick) begin
         if (pre_cnt_q == pre_limit - 6'h1) begin
            pre_cnt_q <= 6'h0;
            wdg_cnt_q <= wdg_cnt_q + 8'h1;
         end else begin
            pre_cnt_q <= pre_cnt_q + 6'h1;
         end
      end
   end

   // expiry on the 256th tick, only while counting is allowed
   assign wdg_reset = wdg_count_en && slow_tick && !wdg_clear &&
      seq_q == RPC_ST_RUN && wdg_cnt_q == 8'hff &&
      pre_cnt_q == pre_limit - 6'h1;

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave

   logic       ph_valid_q;
   logic       ph_write_q;
   logic [7:0] ph_addr_q;
   logic       soft_armed_q;
   logic       soft_reset;
   logic [7:0] cause_q;
   logic       soft_cause_q;
   logic [3:0] irq_stat_q;
   logic [3:0] irq_mask_q;
   logic [7:0] wbyte;
   logic       wr_en;

   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_q <= 1'b0;
         ph_write_q <= 1'b0;
         ph_addr_q  <= 8'h0;
      end else if (hready) begin
         ph_valid_q <= hsel && htrans[1];
         ph_write_q <= hwrite;
         ph_addr_q  <= haddr[9:2];          // word index, one word a register
      end
   end

   assign wr_en = ph_valid_q && ph_write_q;
   assign wbyte = hwdata[7:0];
   assign wdg_clear = wr_en && ph_addr_q == ADDR_WDG_CLEAR &&
      wbyte == WDG_CLEAR_VALUE;

   // two consecutive writes with bit 0 set; any other write disarms
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_armed_q <= 1'b0;
      end else if (seq_q != RPC_ST_RUN) begin
         soft_armed_q <= 1'b0;
      end else if (wr_en && ph_addr_q == ADDR_SOFT_RESET) begin
         soft_armed_q <= wbyte[BIT_SOFT_REQ] && !soft_armed_q;
      end else if (wr_en) begin
         soft_armed_q <= 1'b0;
      end
   end

   assign soft_reset = wr_en && ph_addr_q == ADDR_SOFT_RESET &&
      wbyte[BIT_SOFT_REQ] && soft_armed_q;

   // read mux; watchdog clear is write-only and reads zero
   always_comb begin
      hrdata = 32'h0;
      if (ph_valid_q && !ph_write_q) begin
         unique case (ph_addr_q)
            ADDR_CAUSE:      hrdata = {24'h0, cause_q};
            ADDR_SOFT_RESET: hrdata = {31'h0, soft_cause_q};
            ADDR_IRQ_STATUS: hrdata = {28'h0, irq_stat_q};
            ADDR_IRQ_MASK:   hrdata = {28'h0, irq_mask_q};
            default:         hrdata = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset merge and power-on sequence

   logic        hw_reset;
   logic [31:0] seq_cnt_q;

   assign hw_reset = uv_sync_q || wdg_reset || pin_reset;

   // sources hold the sequence in reset; software reset goes straight on
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq_q     <= RPC_ST_HELD;
         seq_cnt_q <= 32'h0;
      end else if (hw_reset) begin
         seq_q     <= RPC_ST_HELD;
         seq_cnt_q <= 32'h0;
      end else begin
         unique case (seq_q)
            RPC_ST_HELD: begin
               seq_q     <= RPC_ST_PWR_WAIT;
               seq_cnt_q <= 32'h0;
            end
            RPC_ST_PWR_WAIT: begin
               if (seq_cnt_q >= 32'(PWR_STAB_CYCLES - 1)) begin
                  seq_q     <= RPC_ST_CLK_WAIT;
                  seq_cnt_q <= 32'h0;
               end else begin
                  seq_cnt_q <= seq_cnt_q + 32'h1;
               end
            end
            RPC_ST_CLK_WAIT: begin
               if (clk_source_tick) begin
                  if (seq_cnt_q >= 32'(CLK_STAB_PERIODS - 1)) begin
                     seq_q <= RPC_ST_RUN;
                  end
                  seq_cnt_q <= seq_cnt_q + 32'h1;
               end
            end
            RPC_ST_RUN: begin
               seq_cnt_q <= 32'h0;            // software reset skips waits
            end
         endcase
      end
   end

   // clock source selection followed during the power stabilisation wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_sel_q <= 3'h0;
      end else if (seq_q == RPC_ST_PWR_WAIT) begin
         clk_sel_q <= cfg_clk_source;
      end
   end

   // one-cycle software reset pulse to the system
   logic soft_pulse_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_pulse_q <= 1'b0;
      end else begin
         soft_pulse_q <= soft_reset;
      end
   end

   // cause flags are rewritten by every new reset, software included; hresetn clears them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cause_q      <= 8'h0;
         soft_cause_q <= 1'b0;
      end else if (hw_reset || soft_reset) begin
         cause_q[BIT_CAUSE_UV]  <= uv_sync_q;
         cause_q[BIT_CAUSE_WDG] <= wdg_reset;
         cause_q[BIT_CAUSE_PIN] <= pin_reset;
         soft_cause_q           <= soft_reset && !hw_reset;
      end
   end

   // interrupt status: set wins over write-one-to-clear
   logic [3:0] irq_set;
   assign irq_set = {soft_reset, pin_reset, wdg_reset, uv_sync_q};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_q <= IRQ_RESET_VAL;
         irq_mask_q <= IRQ_RESET_VAL;
      end else begin
         if (wr_en && ph_addr_q == ADDR_IRQ_MASK) begin
            irq_mask_q <= wbyte[3:0];
         end
         if (wr_en && ph_addr_q == ADDR_IRQ_STATUS) begin
            irq_stat_q <= (irq_stat_q & ~wbyte[3:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
      end
   end

   // outputs
   assign irq              = |(irq_stat_q & irq_mask_q);
   assign cpu_run          = (seq_q == RPC_ST_RUN) && !soft_pulse_q;
   assign sys_reset_n      = cpu_run;
   assign clk_source_sel   = clk_sel_q;
   assign clk_source_start = (seq_q == RPC_ST_CLK_WAIT) ||
      (seq_q == RPC_ST_RUN);
   assign fetch_address    = RESET_VECTOR;

endmodule // rpc_reset_ctrl

// ### rpc_reset_ctrl_props.sv
// concurrent checks on the reset and power-on controller ports
`timescale 1ns/10ps
module rpc_reset_ctrl_props
   import rpc_pkg::*;
#(
   parameter int PWR_STAB_CYCLES = PWR_STAB_CYC
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        undervoltage_level_low,
   input wire logic        sys_reset_n,
   input wire logic        cpu_run,
   input wire logic [2:0]  clk_source_sel,
   input wire logic        clk_source_start,
   input wire logic        clk_source_tick,
   input wire logic [15:0] fetch_address
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////
   logic [12:0] tick_cnt_q;
   logic [31:0] pwr_cnt_q;

   // source ticks since start; saturates so a software restart still passes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q <= 13'h0;
      end else if (!clk_source_start) begin
         tick_cnt_q <= 13'h0;
      end else if (clk_source_tick && tick_cnt_q != 13'h1000) begin
         tick_cnt_q <= tick_cnt_q + 13'h1;
      end
   end

   // cycles spent with the clock source stopped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_cnt_q <= 32'h0;
      end else if (clk_source_start) begin
         pwr_cnt_q <= 32'h0;
      end else begin
         pwr_cnt_q <= pwr_cnt_q + 32'h1;
      end
   end

   sequence rd_of(logic [7:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr[9:2] == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_UV_RESET: assert property (
      undervoltage_level_low [*4] |-> ##[0:2] !sys_reset_n)
      else $error("undervoltage did not reset");
   AST_FETCH: assert property (
      cpu_run |-> fetch_address == RESET_VECTOR)
      else $error("fetch address not reset vector");
   AST_CLK_RUN: assert property (cpu_run |-> clk_source_start)
      else $error("running without clock source");
   AST_STAB_TICKS: assert property (
      $rose(cpu_run) |-> tick_cnt_q == CLK_STAB_PERIODS)
      else $error("run began before 4096 source periods");
   AST_PWR_WAIT: assert property (
      $rose(clk_source_start) && !$past(cpu_run, 2)
      |-> pwr_cnt_q >= PWR_STAB_CYCLES)
      else $error("power wait too short");
   AST_SOFT_SKIP: assert property (
      $fell(cpu_run) ##1 clk_source_start |-> cpu_run)
      else $error("software restart not one cycle");
   AST_SEL_HOLD: assert property (
      cpu_run && $past(cpu_run) |-> $stable(clk_source_sel))
      else $error("clock selection moved while running");
   AST_CLR_WO: assert property (
      rd_of(ADDR_WDG_CLEAR) |=> hrdata == 32'h0)
      else $error("watchdog clear readable");
   AST_CAUSE_LOW: assert property (
      rd_of(ADDR_CAUSE) |=> hrdata[4:0] == 5'h00)
      else $error("cause low bits not zero");

   // main scenarios reached
   COV_RUN: cover property ($rose(cpu_run));
   COV_SOFT: cover property ($fell(cpu_run) ##1 cpu_run);
   COV_UV: cover property (undervoltage_level_low [*4]);
endmodule // rpc_reset_ctrl_props

// ### rpc_reset_ctrl_tb_top.sv
// self-checking bench for the reset and power-on controller
`timescale 1ns/10ps
module rpc_reset_ctrl_tb_top;
   import rpc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, uv, pin_low, slow, rd_ph_q;
   logic        hreadyout, hresp, sys_reset_n, cpu_run, tick, pin_n;
   logic        clk_start, irq, deb;
   rpc_wdg_mode_e mode;
   logic [31:0] haddr, hwdata, hrdata, lfsr;
   logic [1:0]  htrans, cpu_state;
   logic [2:0]  hsize, src, clk_source_sel;
   logic [15:0] fetch_address;
   logic [31:0] exp_q[$];
   int          fail_count, tests_run, low_cnt, cyc, saved;

   rpc_reset_ctrl #(.PWR_STAB_CYCLES(20), .DEBOUNCE_CYCLES(16),
      .SLOW_TICK_CYCLES(2)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .undervoltage_level_low(uv), .reset_pin_n(pin_n),
      .cfg_wdg_mode(mode), .cfg_wdg_prescale(2'h0),
      .cfg_pin_reset_en(1'b1), .cfg_pin_debounce(deb),
      .cfg_clk_source(src), .cpu_state(cpu_state), .clk_source_tick(tick),
      .sys_reset_n(sys_reset_n), .cpu_run(cpu_run),
      .clk_source_sel(clk_source_sel), .clk_source_start(clk_start),
      .fetch_address(fetch_address), .irq(irq));

   rpc_far_model far_u (.hclk(hclk), .clk_source_start(clk_start),
      .slow(slow), .pin_low(pin_low), .clk_source_tick(tick),
      .reset_pin_n(pin_n));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one single transfer; address held until hready, then data phase
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1; hwrite <= w; htrans <= 2'h2; haddr <= {22'h0, a, 2'h0};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   // upper data bits carry random filler the block must ignore
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      lfsr = lfsr_next(lfsr);
      bus(1'b1, a, {lfsr[31:8], v});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic wait_run();
      int n;
      n = 0;
      while (cpu_run !== 1'b1 && n < 10000) begin
         @(negedge hclk);
         n++;
      end
      check({31'h0, cpu_run}, 32'h1);
      @(posedge hclk);
   endtask

   task automatic look(input logic [31:0] exp, input logic is_irq);
      @(negedge hclk);
      check({31'h0, is_irq ? irq : cpu_run}, exp);
      @(posedge hclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // read data compared one edge after its address phase
   always @(posedge hclk) begin
      if (rd_ph_q) check(hrdata, exp_q.pop_front());
      rd_ph_q <= hsel && htrans[1] && !hwrite && hreadyout;
   end

   // cycles not running, and the hang limit
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (hresetn && cpu_run !== 1'b1) low_cnt <= low_cnt + 1;
      if (cyc == 60000) begin
         fail_count++;
         results();
      end
   end

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; uv = 1'b0;
      pin_low = 1'b0; slow = 1'b0; cpu_state = 2'h0; rd_ph_q = 1'b0;
      deb = 1'b1; mode = RPC_WDG_ENABLED;
      fail_count = 0; tests_run = 0; low_cnt = 0; cyc = 0;
      lfsr = lfsr_next(32'haba8);
      src = lfsr[6:4];
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      wait_run();
      check({29'h0, clk_source_sel}, {29'h0, src});
      check({16'h0, fetch_address}, 32'h0);
      rd(ADDR_CAUSE, 32'h0);
      rd(ADDR_WDG_CLEAR, 32'h0);
      rd(8'h90, 32'h0);
      // timely clears, and an idle stretch, keep the watchdog quiet
      saved = low_cnt;
      for (int i = 0; i < 3; i++) begin
         repeat (1500) @(posedge hclk);
         wr(ADDR_WDG_CLEAR, WDG_CLEAR_VALUE);
      end
      cpu_state <= 2'h1;
      repeat (2500) @(posedge hclk);
      cpu_state <= 2'h0;
      wr(ADDR_WDG_CLEAR, WDG_CLEAR_VALUE);
      check(low_cnt, saved);
      // a wrong value must not restart the timer: 2048 cycles to expiry
      repeat (1500) @(posedge hclk);
      wr(ADDR_WDG_CLEAR, {lfsr[7:1], 1'b1});
      repeat (600) @(posedge hclk);
      look(32'h0, 1'b0);
      wait_run();
      rd(ADDR_CAUSE, 32'h40);
      rd(ADDR_IRQ_STATUS, 32'h02);
      wr(ADDR_IRQ_MASK, 8'h00);
      look(32'h0, 1'b1);
      wr(ADDR_IRQ_MASK, 8'h02);
      look(32'h1, 1'b1);
      wr(ADDR_IRQ_STATUS, 8'h02);
      look(32'h0, 1'b1);
      // an unrelated write between two requests breaks the pair
      saved = low_cnt;
      wr(ADDR_SOFT_RESET, 8'h01);
      wr(ADDR_IRQ_MASK, 8'h02);
      wr(ADDR_SOFT_RESET, 8'h01);
      repeat (4) @(posedge hclk);
      check(low_cnt, saved);
      wr(ADDR_SOFT_RESET, 8'h01);
      repeat (6) @(posedge hclk);
      check(low_cnt, saved + 1);
      rd(ADDR_SOFT_RESET, 32'h01);
      // cause flags follow the latest reset, software included
      rd(ADDR_CAUSE, 32'h00);
      // short pin pulses are filtered, a long one resets
      saved = low_cnt;
      for (int i = 0; i < 4; i++) begin
         pin_low <= 1'b1;
         repeat (8) @(posedge hclk);
         pin_low <= 1'b0;
         repeat (8) @(posedge hclk);
      end
      check(low_cnt, saved);
      // a strap dropped while running waits for the next reset
      pin_low <= 1'b1;
      deb     <= 1'b0;
      repeat (8) @(posedge hclk);
      look(32'h1, 1'b0);
      repeat (31) @(posedge hclk);
      look(32'h0, 1'b0);
      pin_low <= 1'b0;
      wait_run();
      rd(ADDR_CAUSE, 32'h20);
      // without debounce a short low resets at once
      pin_low <= 1'b1;
      repeat (4) @(posedge hclk);
      look(32'h0, 1'b0);
      pin_low <= 1'b0;
      wait_run();
      rd(ADDR_CAUSE, 32'h20);
      // undervoltage, with the clock source answering slowly
      slow <= 1'b1;
      uv   <= 1'b1;
      mode <= RPC_WDG_ALWAYS;
      repeat (10) @(posedge hclk);
      uv <= 1'b0;
      look(32'h0, 1'b0);
      wait_run();
      rd(ADDR_CAUSE, 32'h80);
      // always-on watchdog still expires while the cpu is stopped
      cpu_state <= 2'h2;
      repeat (2100) @(posedge hclk);
      look(32'h0, 1'b0);
      results();
   end
endmodule // rpc_reset_ctrl_tb_top

bind rpc_reset_ctrl rpc_reset_ctrl_props #(
   .PWR_STAB_CYCLES(PWR_STAB_CYCLES)) props_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .undervoltage_level_low(undervoltage_level_low),
   .sys_reset_n(sys_reset_n), .cpu_run(cpu_run),
   .clk_source_sel(clk_source_sel), .clk_source_start(clk_source_start),
   .clk_source_tick(clk_source_tick), .fetch_address(fetch_address));
